// ### rtl/pcec_parity.sv
// Even parity over a word: result makes the total count of ones even
module pcec_parity #(
   parameter int W = 36
) (
   input wire logic [W-1:0] data,
   output logic par
);

   // Plain reduction; cheap enough to keep combinational
   assign par = ^data;

endmodule

// ### rtl/pcec_pkg.sv
package pcec_pkg;

   // ------------------------------------------------------------------
   // Register indices on the plain register port
   // ------------------------------------------------------------------
   localparam logic [3:0] PCEC_IDX_CMD = 4'h0;      // Command word
   localparam logic [3:0] PCEC_IDX_STATUS = 4'h1;   // Status word
   localparam logic [3:0] PCEC_IDX_IRQ_STAT = 4'h2; // Sticky events, read only
   localparam logic [3:0] PCEC_IDX_IRQ_CLR = 4'h3;  // Write one to clear
   localparam logic [3:0] PCEC_IDX_IRQ_EN = 4'h4;   // Interrupt enables

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int PCEC_CMD_SYS_ERR_EN_BIT = 8;  // System-error drive enable
   localparam int PCEC_CMD_STEP_BIT = 7;   // Stepping control
   localparam int PCEC_CMD_PAR_RESP_BIT = 6;    // Parity error response
   localparam int PCEC_STAT_PAR_FLAG_BIT = 15;  // Detected parity error
   localparam int PCEC_EV_DATA_BIT = 0;    // Data parity error event
   localparam int PCEC_EV_ADDR_BIT = 1;    // Address parity error event
   localparam int PCEC_EV_W = 2;           // Number of interrupt events

   // ------------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------------
   localparam logic PCEC_RST_SYS_ERR_EN = 1'h0;
   localparam logic PCEC_RST_STEP_EITHER = 1'h1;
   localparam logic PCEC_RST_PAR_RESP = 1'h0;
   localparam logic PCEC_RST_PAR_FLAG = 1'h0;
   localparam logic [1:0] PCEC_RST_EV = 2'h0;
   localparam logic [15:0] PCEC_RST_WORD = 16'h0000;

   // ------------------------------------------------------------------
   // Stepping capability of the device
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      PCEC_STEP_NEVER = 3'h1,
      PCEC_STEP_ALWAYS = 3'h2,
      PCEC_STEP_EITHER = 3'h4
   } pcec_step_e;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ad;
      logic [3:0] cbe;
   } pcec_bus_s;

   typedef struct packed {
      logic valid;       // Phase to be checked
      logic addr_phase;  // 1 address phase, 0 data phase
      pcec_bus_s bus;    // Sampled address/data and byte enables
      logic par;         // Sampled parity pin
   } pcec_chk_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pcec_req_s;

endpackage

// ### rtl/pcec_top.sv
// Added by the designer: the register addresses and the strobed register port.
module pcec_top #(
   parameter pcec_pkg::pcec_step_e STEP_MODE = pcec_pkg::PCEC_STEP_EITHER
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire pcec_pkg::pcec_req_s req,
   output logic [15:0] rdata,
   input wire pcec_pkg::pcec_chk_s chk_pin,
   input wire logic tx_valid,
   input wire pcec_pkg::pcec_bus_s tx_bus,
   output logic par_out,
   output logic par_oe,
   output logic perr_n_out,
   output logic perr_oe,
   output logic serr_n_out,
   output logic serr_oe,
   output logic irq
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   pcec_pkg::pcec_chk_s chk_meta_reg; // First stage, read only by second
   pcec_pkg::pcec_chk_s chk_reg;      // Stable copy for the checker

   // Two flops before the checker sees any pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chk_meta_reg <= '0;
         chk_reg <= '0;
      end else begin
         chk_meta_reg <= chk_pin;
         chk_reg <= chk_meta_reg;
      end
   end

   // ------------------------------------------------------------------
   // Command bits
   // ------------------------------------------------------------------
   logic sys_err_en_reg;    // system_error_drive_enable
   logic par_resp_reg;      // parity_error_response
   logic step_rw_reg;  // Writable stepping bit, either-mode only
   logic step_bit;     // stepping_control_bit as seen by software
   logic wr_cmd;       // Write to the command word
   logic wr_stat;      // Write to the status word
   logic wr_clr;       // Write to the interrupt clear word
   logic wr_en;        // Write to the interrupt enable word

   assign wr_cmd = req.wr && (req.addr == pcec_pkg::PCEC_IDX_CMD);
   assign wr_stat = req.wr && (req.addr == pcec_pkg::PCEC_IDX_STATUS);
   assign wr_clr = req.wr && (req.addr == pcec_pkg::PCEC_IDX_IRQ_CLR);
   assign wr_en = req.wr && (req.addr == pcec_pkg::PCEC_IDX_IRQ_EN);

   // Enable bits; both come up cleared so no error signalling by default
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sys_err_en_reg <= pcec_pkg::PCEC_RST_SYS_ERR_EN;
         par_resp_reg <= pcec_pkg::PCEC_RST_PAR_RESP;
      end else if (wr_cmd) begin
         sys_err_en_reg <= req.wdata[pcec_pkg::PCEC_CMD_SYS_ERR_EN_BIT];
         par_resp_reg <= req.wdata[pcec_pkg::PCEC_CMD_PAR_RESP_BIT];
      end
   end

   // Stepping bit is only stored when the device can run both ways
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_rw_reg <= pcec_pkg::PCEC_RST_STEP_EITHER;
      end else if (wr_cmd && (STEP_MODE == pcec_pkg::PCEC_STEP_EITHER)) begin
         step_rw_reg <= req.wdata[pcec_pkg::PCEC_CMD_STEP_BIT];
      end
   end

   // Fixed-capability parts ignore writes to the stepping bit
   always_comb begin
      case (STEP_MODE)
         pcec_pkg::PCEC_STEP_NEVER: step_bit = 1'b0;
         pcec_pkg::PCEC_STEP_ALWAYS: step_bit = 1'b1;
         pcec_pkg::PCEC_STEP_EITHER: step_bit = step_rw_reg;
         default: step_bit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // Parity check
   // ------------------------------------------------------------------
   logic chk_calc;   // Parity computed over the sampled phase
   logic par_err;    // Sampled parity pin disagrees
   logic data_err;   // Parity error in a data phase
   logic addr_err;   // Parity error in an address phase

   pcec_parity #(.W(36)) u_chk_par (
      .data(chk_reg.bus),
      .par(chk_calc)
   );

   assign par_err = chk_reg.valid && (chk_calc != chk_reg.par);
   assign data_err = par_err && !chk_reg.addr_phase;
   assign addr_err = par_err && chk_reg.addr_phase;

   // ------------------------------------------------------------------
   // Error signalling
   // ------------------------------------------------------------------
   logic par_flag_reg;  // detected_parity_error_flag

   // PERR# is driven only when the response bit allows it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         perr_oe <= 1'b0;
         perr_n_out <= 1'b1;
      end else begin
         perr_oe <= data_err && par_resp_reg;
         perr_n_out <= !(data_err && par_resp_reg);
      end
   end

   // SERR# needs both enables; the driver is off while its bit is clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serr_oe <= 1'b0;
         serr_n_out <= 1'b1;
      end else begin
         serr_oe <= addr_err && sys_err_en_reg && par_resp_reg;
         serr_n_out <= !(addr_err && sys_err_en_reg && par_resp_reg);
      end
   end

   // Flag is set on any detected error whatever the response bit says;
   // a new error in the clearing cycle wins over the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         par_flag_reg <= pcec_pkg::PCEC_RST_PAR_FLAG;
      end else if (par_err) begin
         par_flag_reg <= 1'b1;
      end else if (wr_stat && req.wdata[pcec_pkg::PCEC_STAT_PAR_FLAG_BIT]) begin
         par_flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Parity generation
   // ------------------------------------------------------------------
   logic tx_calc;  // Parity of the outgoing phase

   pcec_parity #(.W(36)) u_tx_par (
      .data(tx_bus),
      .par(tx_calc)
   );

   // Generated for every driven phase, independent of checking enables
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         par_out <= 1'b0;
         par_oe <= 1'b0;
      end else begin
         par_out <= tx_valid ? tx_calc : 1'b0;
         par_oe <= tx_valid;
      end
   end

   // ------------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------------
   logic [1:0] ev_reg;  // Sticky event bits
   logic [1:0] en_reg;  // Interrupt enables
   logic [1:0] ev_set;  // Events of this cycle

   assign ev_set = {addr_err, data_err};

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ev_reg <= pcec_pkg::PCEC_RST_EV;
      end else begin
         ev_reg <= ev_set | (ev_reg & ~(wr_clr ? req.wdata[1:0] : 2'h0));
      end
   end

   // Enables only steer the output, never the sticky bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_reg <= pcec_pkg::PCEC_RST_EV;
      end else if (wr_en) begin
         en_reg <= req.wdata[1:0];
      end
   end

   // Level output; follows the sticky bits one cycle later
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_reg & en_reg);
      end
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   logic [15:0] rd_next;  // Word selected by the read address

   // Unmapped offsets and the write-only clear word read as zero
   always_comb begin
      rd_next = pcec_pkg::PCEC_RST_WORD;
      case (req.addr)
         pcec_pkg::PCEC_IDX_CMD: begin
            rd_next[pcec_pkg::PCEC_CMD_SYS_ERR_EN_BIT] = sys_err_en_reg;
            rd_next[pcec_pkg::PCEC_CMD_STEP_BIT] = step_bit;
            rd_next[pcec_pkg::PCEC_CMD_PAR_RESP_BIT] = par_resp_reg;
         end
         pcec_pkg::PCEC_IDX_STATUS: begin
            rd_next[pcec_pkg::PCEC_STAT_PAR_FLAG_BIT] = par_flag_reg;
         end
         pcec_pkg::PCEC_IDX_IRQ_STAT: rd_next[1:0] = ev_reg;
         pcec_pkg::PCEC_IDX_IRQ_EN: rd_next[1:0] = en_reg;
         default: rd_next = pcec_pkg::PCEC_RST_WORD;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= pcec_pkg::PCEC_RST_WORD;
      end else begin
         rdata <= req.rd ? rd_next : pcec_pkg::PCEC_RST_WORD;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_SERR_OFF: assert property (
      !sys_err_en_reg |=> !serr_oe)
      else $error("SERR driven while its enable is clear");

   AST_STEP_FIXED: assert property (
      req.rd && req.addr == pcec_pkg::PCEC_IDX_CMD
      && STEP_MODE != pcec_pkg::PCEC_STEP_EITHER
      |=> rdata[pcec_pkg::PCEC_CMD_STEP_BIT] == (STEP_MODE == pcec_pkg::PCEC_STEP_ALWAYS))
      else $error("Stepping bit does not match capability");

   AST_STEP_RW: assert property (
      wr_cmd && STEP_MODE == pcec_pkg::PCEC_STEP_EITHER
      ##1 req.rd && req.addr == pcec_pkg::PCEC_IDX_CMD
      |=> rdata[pcec_pkg::PCEC_CMD_STEP_BIT] == $past(req.wdata[7], 2))
      else $error("Stepping bit did not keep written value");

   AST_RESP_SIGNAL: assert property (
      data_err && par_resp_reg |=> perr_oe && !perr_n_out ##1 !perr_oe)
      else $error("PERR not pulsed for a data parity error");

   AST_RESP_QUIET: assert property (
      par_err && !par_resp_reg |=> !perr_oe && par_flag_reg)
      else $error("Disabled response still drove PERR or lost flag");

   AST_RESP_RESET: assert property (
      $rose(par_resp_reg) |-> $past(wr_cmd))
      else $error("Response bit set without a command write");

   AST_PAR_GEN: assert property (
      tx_valid |=> par_oe && par_out == ^$past(tx_bus))
      else $error("Generated parity wrong");

   AST_ADDR_REPORT: assert property (
      addr_err |=> serr_oe == $past(sys_err_en_reg && par_resp_reg))
      else $error("Address error report does not follow both enables");

   AST_IRQ_LEVEL: assert property (
      |(ev_reg & en_reg) |=> irq)
      else $error("Interrupt missing for enabled event");

   COV_DATA_ERR: cover property (data_err && par_resp_reg ##1 perr_oe);
   COV_ADDR_ERR: cover property (addr_err ##1 serr_oe);
   COV_QUIET_ERR: cover property (par_err && !par_resp_reg ##1 par_flag_reg);
   COV_IRQ: cover property ($rose(irq));

endmodule

// ### verification/pcec_agent.sv
// --------------------------------------------------------------------
// Far-side bus agent: presents one sampled phase per request
// --------------------------------------------------------------------
module pcec_agent (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic go,
   input wire logic addr_ph,
   input wire logic bad,
   input wire pcec_pkg::pcec_bus_s word,
   output pcec_pkg::pcec_chk_s chk_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // One phase per request; released lines toggle, returning to the last phase's values every second cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chk_pin <= '0;
      end else if (go) begin
         chk_pin.valid <= 1'b1;
         chk_pin.addr_phase <= addr_ph;
         chk_pin.bus <= word;
         chk_pin.par <= (^word) ^ bad; // Wrong parity only when a test commands it
      end else begin
         chk_pin.valid <= 1'b0;
         chk_pin.bus <= ~chk_pin.bus;
         chk_pin.par <= ~chk_pin.par;
      end
   end
endmodule

// ### verification/pcec_bench.sv
module pcec_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------------------------------------------------------
   // Stimulus and observed signals
   // --------------------------------------------------------------------
   logic clock = 1'b0; // 250 MHz
   logic rst_n = 1'b0;
   pcec_pkg::pcec_req_s req = '0;
   logic [15:0] rdata;
   pcec_pkg::pcec_chk_s chk_pin;
   logic tx_valid = 1'b0;
   pcec_pkg::pcec_bus_s tx_bus = '0;
   logic par_out, par_oe, perr_n_out, perr_oe, serr_n_out, serr_oe, irq;
   logic go = 1'b0; // Agent request
   logic addr_ph = 1'b0;
   logic bad = 1'b0;
   pcec_pkg::pcec_bus_s word = 36'h0;
   int error_cnt = 0;
   int n_checks = 0;

   always #2 clock = ~clock;

   pcec_top uut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .chk_pin(chk_pin),
      .tx_valid(tx_valid), .tx_bus(tx_bus), .par_out(par_out), .par_oe(par_oe),
      .perr_n_out(perr_n_out), .perr_oe(perr_oe), .serr_n_out(serr_n_out),
      .serr_oe(serr_oe), .irq(irq));

   pcec_agent agent (.clock(clock), .rst_n(rst_n), .go(go), .addr_ph(addr_ph), .bad(bad),
      .word(word), .chk_pin(chk_pin));

   // --------------------------------------------------------------------
   // Compare, bus and phase tasks
   // --------------------------------------------------------------------
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clock);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock);
      req.rd <= 1'b0;
      #1;
      cmp16(rdata, exp);
   endtask

   // Sends one phase and counts the error pulses over a fixed window
   task automatic phase(input logic ap, input logic b, input logic [1:0] exp_cnt);
      logic [1:0] cnt;
      cnt = 2'h0;
      @(posedge clock);
      go <= 1'b1;
      addr_ph <= ap;
      bad <= b;
      word <= 36'h5_a5c3_0f17;
      @(posedge clock);
      go <= 1'b0;
      repeat (7) begin
         @(posedge clock);
         #1;
         if (ap ? (serr_oe && !serr_n_out) : (perr_oe && !perr_n_out)) begin
            cnt = cnt + 2'h1;
         end
      end
      cmp16({14'h0, cnt}, {14'h0, exp_cnt});
   endtask

   task automatic tdone(input string name);
      $display("test %s done", name);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      logic [35:0] tv [3];
      tv = '{36'h0_0000_0000, 36'h1_0000_0001, 36'hf_ffff_fffe};
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(4'h0, 16'h0080);
      rd(4'h1, 16'h0000);
      rd(4'h2, 16'h0000);
      tdone("reset");
      // Parity still generated with checking response off
      foreach (tv[i]) begin
         @(posedge clock);
         tx_valid <= 1'b1;
         tx_bus <= tv[i];
         @(posedge clock);
         tx_valid <= 1'b0;
         #1;
         cmp1(par_oe, 1'b1);
         cmp1(par_out, ^tv[i]);
      end
      @(posedge clock);
      #1;
      cmp1(par_oe, 1'b0);
      tdone("transmit");
      phase(1'b0, 1'b1, 2'h0);
      rd(4'h1, 16'h8000);
      wr(4'h1, 16'h8000);
      rd(4'h1, 16'h0000);
      phase(1'b0, 1'b0, 2'h0);
      tdone("response off");
      wr(4'h0, 16'h0040);
      rd(4'h0, 16'h0040);
      phase(1'b0, 1'b1, 2'h1);
      phase(1'b1, 1'b1, 2'h0);
      wr(4'h0, 16'h0180);
      phase(1'b1, 1'b1, 2'h0);
      wr(4'h0, 16'h01c0);
      rd(4'h0, 16'h01c0);
      phase(1'b1, 1'b1, 2'h1);
      phase(1'b1, 1'b0, 2'h0);
      tdone("response on");
      rd(4'h2, 16'h0003);
      rd(4'h3, 16'h0000);
      rd(4'hf, 16'h0000);
      wr(4'h4, 16'h0001);
      repeat (2) @(posedge clock);
      #1;
      cmp1(irq, 1'b1);
      wr(4'h4, 16'h0000);
      repeat (2) @(posedge clock);
      #1;
      cmp1(irq, 1'b0);
      wr(4'h4, 16'h0002);
      wr(4'h3, 16'h0003);
      rd(4'h2, 16'h0000);
      #1;
      cmp1(irq, 1'b0);
      tdone("interrupt");
      end_sim();
   end
endmodule
